// File: inc/icsr_pkg.sv
// constants for the interrupt control and status register block
package icsr_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_SRC    = 128;
   localparam int NUM_EXT    = 5;
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 8;
   localparam int VEC_W      = 7;
   localparam int LVL_W      = 4;
   localparam int PRIO_W     = 3;
   localparam int SRC_PER_PW = 4;

   // ==========================================================
   // word offsets on the register port
   localparam logic [7:0] FLAG_BASE   = 8'h00;
   localparam logic [7:0] ENA_BASE    = 8'h08;
   localparam logic [7:0] PRIO_BASE   = 8'h10;
   localparam logic [7:0] CTRL1_ADDR  = 8'h30;
   localparam logic [7:0] CTRL2_ADDR  = 8'h31;
   localparam logic [7:0] TEST_ADDR   = 8'h32;
   localparam logic [7:0] STATUS_ADDR = 8'h33;
   localparam logic [7:0] CORE_ADDR   = 8'h34;
   localparam logic [7:0] EVT_ADDR    = 8'h35;
   localparam logic [7:0] MASK_ADDR   = 8'h36;
   localparam logic [7:0] FLAG_WORDS  = 8'h08;
   localparam logic [7:0] PRIO_WORDS  = 8'h20;

   // ==========================================================
   // field positions
   localparam int NEST_DIS_BIT = 15;
   localparam int ARITH_BIT    = 4;
   localparam int ADDR_ERR_BIT = 3;
   localparam int STACK_BIT    = 2;
   localparam int OSC_BIT      = 1;
   localparam int ALT_TBL_BIT  = 15;
   localparam int TDIS_BIT     = 14;
   localparam int IPL_LSB      = 5;
   localparam int CPU_PRIORITY_HIGH_BIT_BIT     = 3;
   localparam int CORE_RSV_BIT = 2;
   localparam int ILR_LSB      = 8;
   localparam int EVT_LATCH    = 0;
   localparam int EVT_TRAP     = 1;

   // ==========================================================
   // reset values and fixed codes
   localparam logic [15:0] WORD_RST  = 16'h0000;
   localparam logic [2:0]  IPL_RST   = 3'h0;
   localparam logic [2:0]  IPL_MAX   = 3'h7;
   localparam logic [6:0]  EXT_VEC0  = 7'h00;
   localparam logic [6:0]  EXT_VEC1  = 7'h14;
   localparam logic [6:0]  EXT_VEC2  = 7'h1D;
   localparam logic [6:0]  EXT_VEC3  = 7'h35;
   localparam logic [6:0]  EXT_VEC4  = 7'h36;

endpackage

// File: verilog/icsr_core.sv
// interrupt controller flag, enable, priority, control and status registers
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module icsr_core
   import icsr_pkg::*;
(
   input  logic                clock_in,
   input  logic                rst_b_in,
   input  logic [ADDR_W-1:0]   addr_in,
   input  logic [DATA_W-1:0]   wr_data_in,
   input  logic                wr_in,
   input  logic                rd_in,
   output logic [DATA_W-1:0]   rd_data_out,
   input  logic [NUM_SRC-1:0]  src_req_in,
   input  logic [NUM_EXT-1:0]  ext_pin_in,
   input  logic [3:0]          trap_in,
   input  logic                trap_enter_in,
   input  logic                trap_exit_in,
   input  logic                timed_disable_in,
   input  logic                ack_in,
   output logic                irq_valid_out,
   output logic [VEC_W-1:0]    irq_vector_out,
   output logic [LVL_W-1:0]    irq_level_out,
   output logic [LVL_W-1:0]    cpu_level_out,
   output logic                alt_table_out,
   output logic                int_out
);

   // ==========================================================
   // helpers
   function automatic logic is_word(input logic [7:0] a, input logic [7:0] base,
                                    input logic [7:0] cnt);
      is_word = (a >= base) && (a < base + cnt);
   endfunction

   // ==========================================================
   // state
   logic [NUM_SRC-1:0] request_flag_regs;
   logic [NUM_SRC-1:0] enable_q;
   logic [PRIO_W-1:0]  source_priority_regs [0:NUM_SRC-1];
   logic               nesting_disable;
   logic [3:0]         trap_flags_q;
   logic               alt_table_select;
   logic [NUM_EXT-1:0] ext_polarity_q;
   logic [NUM_EXT-1:0] ext_prev_q;
   logic [2:0]         cpu_priority_bits;
   logic               cpu_priority_high_bit;
   logic [VEC_W-1:0]   latched_vector_number;
   logic [LVL_W-1:0]   latched_new_level;
   logic               present_q;
   logic [1:0]         evt_q;
   logic [1:0]         mask_q;
   logic [DATA_W-1:0]  rd_data_q;

   logic [LVL_W-1:0]   cpu_level;
   logic [NUM_EXT-1:0] ext_edge;
   logic [NUM_SRC-1:0] hw_set;
   logic               win_found;
   logic [VEC_W-1:0]   win_vec;
   logic [PRIO_W-1:0]  win_prio;
   logic [1:0]         evt_set;
   logic [7:0]         widx;
   logic [4:0]         pidx;

   assign cpu_level = {cpu_priority_high_bit, cpu_priority_bits};
   assign widx      = addr_in;
   assign pidx      = 5'(widx - PRIO_BASE);

   // ==========================================================
   // external pins: edge detect with per-pin polarity
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         // track the pins through reset, so a pin idling high gives no false edge
         ext_prev_q <= ext_pin_in;
      end else begin
         ext_prev_q <= ext_pin_in;
      end
   end

   // polarity 1 catches a falling edge, 0 a rising edge
   assign ext_edge = ext_polarity_q & ext_prev_q & ~ext_pin_in |
                     ~ext_polarity_q & ~ext_prev_q & ext_pin_in;

   always_comb begin
      hw_set = src_req_in;
      hw_set[EXT_VEC0] = src_req_in[EXT_VEC0] | ext_edge[0];
      hw_set[EXT_VEC1] = src_req_in[EXT_VEC1] | ext_edge[1];
      hw_set[EXT_VEC2] = src_req_in[EXT_VEC2] | ext_edge[2];
      hw_set[EXT_VEC3] = src_req_in[EXT_VEC3] | ext_edge[3];
      hw_set[EXT_VEC4] = src_req_in[EXT_VEC4] | ext_edge[4];
   end

   // ==========================================================
   // request flags and enables, bit i%16 of word i/16 is source i
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         request_flag_regs <= '0;
      end else begin
         for (int w = 0; w < 8; w++) begin
            // a hardware set in the same cycle as a software clear wins
            if (wr_in && widx == FLAG_BASE + 8'(w)) begin
               request_flag_regs[w*16 +: 16] <= wr_data_in | hw_set[w*16 +: 16];
            end else begin
               request_flag_regs[w*16 +: 16] <= request_flag_regs[w*16 +: 16] |
                                                hw_set[w*16 +: 16];
            end
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         enable_q <= '0;
      end else if (wr_in && is_word(widx, ENA_BASE, FLAG_WORDS)) begin
         enable_q[widx[2:0]*16 +: 16] <= wr_data_in;
      end
   end

   // ==========================================================
   // priorities, four sources per word at bits 2:0, 6:4, 10:8, 14:12
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            source_priority_regs[i] <= '0;
         end
      end else if (wr_in && is_word(widx, PRIO_BASE, PRIO_WORDS)) begin
         for (int k = 0; k < SRC_PER_PW; k++) begin
            source_priority_regs[pidx*SRC_PER_PW + k] <= wr_data_in[k*4 +: 3];
         end
      end
   end

   // ==========================================================
   // global controls
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         nesting_disable  <= 1'b0;
         alt_table_select <= 1'b0;
         ext_polarity_q   <= '0;
      end else if (wr_in && widx == CTRL1_ADDR) begin
         nesting_disable <= wr_data_in[NEST_DIS_BIT];
      end else if (wr_in && widx == CTRL2_ADDR) begin
         alt_table_select <= wr_data_in[ALT_TBL_BIT];
         ext_polarity_q   <= wr_data_in[NUM_EXT-1:0];
      end
   end

   // trap flags are read/write; a trap in the write cycle still lands
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         trap_flags_q <= '0;
      end else if (wr_in && widx == CTRL1_ADDR) begin
         trap_flags_q <= wr_data_in[ARITH_BIT:OSC_BIT] | trap_in;
      end else begin
         trap_flags_q <= trap_flags_q | trap_in;
      end
   end

   // ==========================================================
   // cpu priority level
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         cpu_priority_bits <= IPL_RST;
      end else if (ack_in && present_q) begin
         // with nesting off, taking an interrupt raises the level to the top
         cpu_priority_bits <= nesting_disable ? IPL_MAX : latched_new_level[2:0];
      end else if (wr_in && widx == STATUS_ADDR && !nesting_disable) begin
         cpu_priority_bits <= wr_data_in[IPL_LSB +: 3];
      end
   end

   // only the core moves the high bit, so software can never mask traps
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         cpu_priority_high_bit <= 1'b0;
      end else if (trap_enter_in) begin
         cpu_priority_high_bit <= 1'b1;
      end else if (trap_exit_in) begin
         cpu_priority_high_bit <= 1'b0;
      end
   end

   // ==========================================================
   // arbitration: strict compare keeps the lower vector on a tie
   always_comb begin
      win_found = 1'b0;
      win_vec   = '0;
      win_prio  = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (request_flag_regs[i] && enable_q[i] &&
             {1'b0, source_priority_regs[i]} > cpu_level &&
             !(timed_disable_in && source_priority_regs[i] != IPL_MAX) &&
             source_priority_regs[i] > win_prio) begin
            win_found = 1'b1;
            win_vec   = VEC_W'(i);
            win_prio  = source_priority_regs[i];
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         present_q             <= 1'b0;
         latched_vector_number <= '0;
         latched_new_level     <= '0;
      end else begin
         present_q <= win_found;
         if (win_found) begin
            latched_vector_number <= win_vec;
            latched_new_level     <= {1'b0, win_prio};
         end
      end
   end

   assign irq_valid_out  = present_q;
   assign irq_vector_out = latched_vector_number;
   assign irq_level_out  = latched_new_level;
   assign cpu_level_out  = cpu_level;
   assign alt_table_out  = alt_table_select;

   // ==========================================================
   // event status, mask and interrupt line; a read clears the status
   assign evt_set[EVT_LATCH] = win_found && (!present_q || win_vec != latched_vector_number);
   assign evt_set[EVT_TRAP]  = |trap_in;

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         evt_q <= '0;
      end else if (rd_in && widx == EVT_ADDR) begin
         evt_q <= evt_set;
      end else begin
         evt_q <= evt_q | evt_set;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         mask_q <= '0;
      end else if (wr_in && widx == MASK_ADDR) begin
         mask_q <= wr_data_in[1:0];
      end
   end

   assign int_out = |(evt_q & mask_q);

   // ==========================================================
   // read port, data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         rd_data_q <= WORD_RST;
      end else if (rd_in) begin
         rd_data_q <= WORD_RST;
         if (is_word(widx, FLAG_BASE, FLAG_WORDS)) begin
            rd_data_q <= request_flag_regs[widx[2:0]*16 +: 16];
         end else if (is_word(widx, ENA_BASE, FLAG_WORDS)) begin
            rd_data_q <= enable_q[widx[2:0]*16 +: 16];
         end else if (is_word(widx, PRIO_BASE, PRIO_WORDS)) begin
            for (int k = 0; k < SRC_PER_PW; k++) begin
               rd_data_q[k*4 +: 3] <= source_priority_regs[pidx*SRC_PER_PW + k];
            end
         end else begin
            case (widx)
               CTRL1_ADDR: begin
                  rd_data_q[NEST_DIS_BIT]        <= nesting_disable;
                  rd_data_q[ARITH_BIT:OSC_BIT]   <= trap_flags_q;
               end
               CTRL2_ADDR: begin
                  rd_data_q[ALT_TBL_BIT]         <= alt_table_select;
                  rd_data_q[TDIS_BIT]            <= timed_disable_in;
                  rd_data_q[NUM_EXT-1:0]         <= ext_polarity_q;
               end
               TEST_ADDR: begin
                  rd_data_q[VEC_W-1:0]           <= latched_vector_number;
                  rd_data_q[ILR_LSB +: LVL_W]    <= latched_new_level;
               end
               STATUS_ADDR: begin
                  rd_data_q[IPL_LSB +: 3]        <= cpu_priority_bits;
               end
               CORE_ADDR: begin
                  rd_data_q[CPU_PRIORITY_HIGH_BIT_BIT]            <= cpu_priority_high_bit;
                  rd_data_q[CORE_RSV_BIT]        <= 1'b1;
               end
               EVT_ADDR: begin
                  rd_data_q[1:0]                 <= evt_q;
               end
               MASK_ADDR: begin
                  rd_data_q[1:0]                 <= mask_q;
               end
               default: begin
                  rd_data_q <= WORD_RST;
               end
            endcase
         end
      end
   end

   assign rd_data_out = rd_data_q;

   // ==========================================================
   // checks
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   flag_sticky_a: assert property (
      request_flag_regs[3] && !(wr_in && addr_in == FLAG_BASE) |=> request_flag_regs[3])
      else $error("request flag dropped without a write");

   flag_set_a: assert property (src_req_in[9] |=> request_flag_regs[9])
      else $error("source request did not set its flag");

   ena_write_a: assert property (
      wr_in && addr_in == ENA_BASE |=> enable_q[15:0] == $past(wr_data_in))
      else $error("enable word write did not land");

   prio_map_a: assert property (
      wr_in && addr_in == PRIO_BASE |=> source_priority_regs[0] == $past(wr_data_in[2:0]))
      else $error("first priority word does not hold source 0");

   ext_edge_a: assert property (
      !ext_polarity_q[0] && !ext_pin_in[0] ##1 !ext_polarity_q[0] && ext_pin_in[0]
      |=> request_flag_regs[0])
      else $error("rising edge on external pin 0 missed");

   nest_lock_a: assert property (
      nesting_disable && wr_in && addr_in == STATUS_ADDR && !ack_in
      |=> $stable(cpu_priority_bits))
      else $error("cpu priority changed while nesting is disabled");

   ack_level_a: assert property (
      ack_in && irq_valid_out && !nesting_disable
      |=> {1'b0, cpu_priority_bits} == $past(irq_level_out))
      else $error("taken interrupt did not set the cpu level");

   high_bit_hold_a: assert property (
      !trap_enter_in && !trap_exit_in |=> $stable(cpu_priority_high_bit))
      else $error("cpu high priority bit moved without the core");

   test_latch_a: assert property (
      win_found |=> latched_vector_number == $past(win_vec)
                    && latched_new_level[2:0] == $past(win_prio))
      else $error("test register did not latch the winner");

   level_gate_a: assert property (irq_valid_out |-> irq_level_out > $past(cpu_level))
      else $error("presented level not above cpu level");

   core_read_a: assert property (
      rd_in && addr_in == CORE_ADDR
      |=> rd_data_out == {12'h000, $past(cpu_level) > 4'h7, 1'b1, 2'b00})
      else $error("core control word read wrong");

   ctrl_zero_a: assert property (
      rd_in && addr_in == CTRL1_ADDR |=> rd_data_out[14:5] == 10'h000 && !rd_data_out[0])
      else $error("unimplemented control bits not zero");

   tdis_read_a: assert property (
      rd_in && addr_in == CTRL2_ADDR |=> rd_data_out[TDIS_BIT] == $past(timed_disable_in))
      else $error("timed disable status read wrong");

   trap_flag_a: assert property (
      trap_in[3] |=> trap_flags_q[3] ##1 trap_flags_q[3] || $past(wr_in))
      else $error("arithmetic trap flag not held");

endmodule

// File: test/icsr_cpu_model.sv
// stand-in for the cpu core and the peripheral request sources
`timescale 1ns/1ps
// ==========================================================
// core and sources
module icsr_cpu_model
   import icsr_pkg::*;
(
   input  logic               clock_in,
   input  logic               rst_b_in,
   input  logic               irq_valid_in,
   input  logic [3:0]         ack_delay_in,
   input  logic               go_in,
   input  logic [NUM_SRC-1:0] req_mask_in,
   output logic               ack_out,
   output logic [NUM_SRC-1:0] src_req_out
);
   logic [3:0] wait_q;
   logic       taken_q;
   // one-cycle pulses, so one request sets its flag once
   always @(posedge clock_in) begin
      src_req_out <= go_in ? req_mask_in : '0;
   end
   // acks once per presentation after a chosen number of cycles
   always @(posedge clock_in) begin
      if (!rst_b_in || !irq_valid_in) begin
         wait_q  <= 4'h0;
         taken_q <= 1'b0;
         ack_out <= 1'b0;
      end else begin
         wait_q  <= wait_q + 4'h1;
         ack_out <= !taken_q && (wait_q + 4'h1 == ack_delay_in);
         if (wait_q + 4'h1 == ack_delay_in) begin
            taken_q <= 1'b1;
         end
      end
   end
endmodule

// File: test/icsr_core_bench.sv
// self-checking bench for the interrupt control and status registers
`timescale 1ns/1ps
module icsr_core_bench
   import icsr_pkg::*;
;
   logic               clock_in = 1'b0;
   logic               rst_b_in = 1'b0;
   logic [ADDR_W-1:0]  addr_in = '0;
   logic [DATA_W-1:0]  wr_data_in = '0;
   logic               wr_in = 1'b0;
   logic               rd_in = 1'b0;
   logic [DATA_W-1:0]  rd_data_out;
   logic [NUM_SRC-1:0] src_req_in;
   logic [NUM_EXT-1:0] ext_pin_in = 5'h0A;
   logic [3:0]         trap_in = 4'h0;
   logic               trap_enter_in = 1'b0;
   logic               trap_exit_in = 1'b0;
   logic               timed_disable_in = 1'b0;
   logic               ack_in;
   logic               irq_valid_out;
   logic [VEC_W-1:0]   irq_vector_out;
   logic [LVL_W-1:0]   irq_level_out;
   logic [LVL_W-1:0]   cpu_level_out;
   logic               alt_table_out;
   logic               int_out;
   logic               go = 1'b0;
   logic [NUM_SRC-1:0] req_mask = '0;
   logic [3:0]         ack_delay = 4'h1;
   int                 bad_count = 0;
   int                 samples_checked = 0;
   int unsigned        seed = 9;
   int                 pri [NUM_SRC];
   bit                 en [NUM_SRC];
   bit                 flg [NUM_SRC];

   always #5 clock_in = ~clock_in;

   icsr_core DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
      .src_req_in(src_req_in), .ext_pin_in(ext_pin_in), .trap_in(trap_in),
      .trap_enter_in(trap_enter_in), .trap_exit_in(trap_exit_in),
      .timed_disable_in(timed_disable_in), .ack_in(ack_in), .irq_valid_out(irq_valid_out),
      .irq_vector_out(irq_vector_out), .irq_level_out(irq_level_out),
      .cpu_level_out(cpu_level_out), .alt_table_out(alt_table_out), .int_out(int_out));

   icsr_cpu_model cpu (.clock_in(clock_in), .rst_b_in(rst_b_in), .irq_valid_in(irq_valid_out),
      .ack_delay_in(ack_delay), .go_in(go), .req_mask_in(req_mask), .ack_out(ack_in),
      .src_req_out(src_req_in));

   // ==========================================================
   // helpers
   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [15:0] pack(input int k, input int i);
      logic [15:0] r;
      r = '0;
      for (int b = 0; b < 16; b++) begin
         if (k == 2 && b % 4 < 3) r[b] = pri[4 * i + b / 4][b % 4];
         if (k == 1) r[b] = en[16 * i + b];
         if (k == 0) r[b] = flg[16 * i + b];
      end
      return r;
   endfunction

   // highest priority wins, strict compare keeps the lowest vector on ties
   function automatic int winner(input int lvl, input int td);
      int best;
      best = -1;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (flg[s] && en[s] && pri[s] > lvl && (td == 0 || pri[s] == 7) &&
             (best < 0 || pri[s] > pri[best])) best = s;
      end
      return best;
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_in);
      wr_in      <= 1'b1;
      addr_in    <= a;
      wr_data_in <= d;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      // data stand through the next cycle; take them at its closing edge
      @(posedge clock_in);
      d = rd_data_out;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask

   // drops nesting disable first, or the level write would be ignored
   task automatic clr_all();
      logic [15:0] d;
      wr(CTRL1_ADDR, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr(ENA_BASE + 8'(i), 16'h0000);
         wr(FLAG_BASE + 8'(i), 16'h0000);
      end
      wr(STATUS_ADDR, 16'h0000);
      rd(EVT_ADDR, d);
      flg = '{default: 1'b0};
      en  = '{default: 1'b0};
   endtask

   // ==========================================================
   // main sequence
   initial begin
      int v, w, win, lvl, td, nd, n, el;
      tick(5);
      rst_b_in <= 1'b1;
      rchk(CTRL1_ADDR, 16'h0000);
      rchk(CTRL2_ADDR, 16'h0000);
      rchk(STATUS_ADDR, 16'h0000);
      rchk(CORE_ADDR, 16'h0004);
      rchk(8'h37, 16'h0000);
      $display("reset values done");
      wr(CTRL2_ADDR, 16'h000A);
      clr_all();
      ext_pin_in <= 5'h15;
      tick(6);
      rchk(FLAG_BASE, 16'h0001);
      rchk(FLAG_BASE + 8'h01, 16'h2010);
      rchk(FLAG_BASE + 8'h03, 16'h0060);
      clr_all();
      ext_pin_in <= 5'h0A;
      tick(6);
      for (int i = 0; i < 4; i++) rchk(FLAG_BASE + 8'(i), 16'h0000);
      $display("edge polarity done");
      wr(CTRL1_ADDR, 16'hFFFF);
      rchk(CTRL1_ADDR, 16'h801E);
      wr(CTRL2_ADDR, 16'hFFFF);
      rchk(CTRL2_ADDR, 16'h801F);
      chk(16'(alt_table_out), 16'h0001);
      timed_disable_in <= 1'b1;
      rchk(CTRL2_ADDR, 16'hC01F);
      wr(CTRL2_ADDR, 16'h0000);
      rchk(CTRL2_ADDR, 16'h4000);
      chk(16'(alt_table_out), 16'h0000);
      timed_disable_in <= 1'b0;
      wr(CTRL1_ADDR, 16'h8000);
      wr(STATUS_ADDR, 16'h0040);
      rchk(STATUS_ADDR, 16'h0000);
      wr(CTRL1_ADDR, 16'h0000);
      wr(STATUS_ADDR, 16'hFFFF);
      rchk(STATUS_ADDR, 16'h00E0);
      // every enable is off here, so the priority fields can be exercised freely
      wr(PRIO_BASE, 16'hFFFF);
      rchk(PRIO_BASE, 16'h7777);
      wr(PRIO_BASE, 16'h0000);
      trap_enter_in <= 1'b1;
      @(posedge clock_in);
      trap_enter_in <= 1'b0;
      wr(CORE_ADDR, 16'h0000);
      rchk(CORE_ADDR, 16'h000C);
      chk(16'(cpu_level_out), 16'h000F);
      trap_exit_in <= 1'b1;
      @(posedge clock_in);
      trap_exit_in <= 1'b0;
      rchk(CORE_ADDR, 16'h0004);
      chk(16'(cpu_level_out), 16'h0007);
      wr(MASK_ADDR, 16'h0002);
      for (int t = 0; t < 4; t++) begin
         trap_in <= 4'(1 << t);
         @(posedge clock_in);
         trap_in <= 4'h0;
         rchk(CTRL1_ADDR, 16'(2 << t));
         chk(16'(int_out), 16'h0001);
         wr(CTRL1_ADDR, 16'h0000);
         rchk(EVT_ADDR, 16'h0002);
         chk(16'(int_out), 16'h0000);
      end
      $display("control registers done");
      wr(MASK_ADDR, 16'h0001);
      for (int it = 0; it < 16; it++) begin
         clr_all();
         v = rnd() % NUM_SRC;
         w = rnd() % NUM_SRC;
         pri[v] = rnd() % 8;
         pri[w] = rnd() % 8;
         en[v] = 1'b1;
         en[w] = 1'(rnd() % 2);
         flg[v] = 1'b1;
         flg[w] = 1'b1;
         lvl = rnd() % 4;
         td = rnd() % 4 == 0;
         nd = rnd() % 2;
         wr(PRIO_BASE + 8'(v / 4), pack(2, v / 4));
         wr(PRIO_BASE + 8'(w / 4), pack(2, w / 4));
         wr(ENA_BASE + 8'(v / 16), pack(1, v / 16));
         wr(ENA_BASE + 8'(w / 16), pack(1, w / 16));
         wr(STATUS_ADDR, 16'(lvl << 5));
         wr(CTRL1_ADDR, 16'(nd << 15));
         timed_disable_in <= 1'(td);
         ack_delay <= 4'(1 + rnd() % 4);
         req_mask <= (NUM_SRC'(1) << v) | (NUM_SRC'(1) << w);
         go <= 1'b1;
         @(posedge clock_in);
         go <= 1'b0;
         tick(2);
         @(negedge clock_in);
         win = winner(lvl, td);
         chk(16'(irq_valid_out), 16'(win >= 0));
         if (win >= 0) begin
            chk(16'(irq_vector_out), 16'(win));
            chk(16'(irq_level_out), 16'(pri[win]));
            chk(16'(int_out), 16'h0001);
            rchk(TEST_ADDR, 16'((pri[win] << ILR_LSB) | win));
            el = nd ? 7 : pri[win];
            for (n = 0; n < 20 && cpu_level_out !== 4'(el); n++) @(negedge clock_in);
            // a level that never arrives counts once and leaves for the report
            if (n == 20) begin
               bad_count++;
               break;
            end
            chk(16'(cpu_level_out), 16'(el));
            tick(2);
            @(negedge clock_in);
            chk(16'(irq_valid_out), 16'h0000);
         end
         rchk(FLAG_BASE + 8'(v / 16), pack(0, v / 16));
         rchk(ENA_BASE + 8'(w / 16), pack(1, w / 16));
      end
      $display("arbitration done");
      wrap_up();
   end
endmodule
